// [core/cesh_params.svh]
// Constants for the communication error stop handler
`ifndef CESH_PARAMS_SVH
`define CESH_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CESH_ADDR_WAIT   8'h00
`define CESH_ADDR_COUNT  8'h04
`define CESH_ADDR_MODE   8'h08
`define CESH_ADDR_STATUS 8'h0C
`define CESH_ADDR_HIST   8'h10

// ----------------------------------------
// Widths, reset values and limits
// ----------------------------------------
`define CESH_WAIT_W      14
`define CESH_CNT_W       16
`define CESH_WAIT_RST    14'h0000
`define CESH_WAIT_MAX    14'h270E
`define CESH_CNT_RST     16'h0000
`define CESH_CNT_MAX     16'hFFFF
`define CESH_MODE_RST    2'h0

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define CESH_ST_ALARM    0
`define CESH_ST_IND      1
`define CESH_ST_COAST    2
`define CESH_ST_DECEL    3
`define CESH_ST_XSTOP    4
`define CESH_ST_CODE_LO  8
`define CESH_ST_STATE_LO 16

// ----------------------------------------
// Alarm data codes
// ----------------------------------------
`define CESH_CODE_NONE   8'h00
`define CESH_CODE_HA1    8'hA1
`define CESH_CODE_HA3    8'hA3
`define CESH_CODE_HF1    8'hF1
`define CESH_CODE_HF3    8'hF3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CESH_CLK_NS      5
`define CESH_TICK_MS     100
`define CESH_HOUR_MS     3600000
`define CESH_TICK_CYC    (`CESH_TICK_MS * 1000000 / `CESH_CLK_NS)
`define CESH_HOUR_TICKS  (`CESH_HOUR_MS / `CESH_TICK_MS)

`endif

// [core/cesh_pkg.sv]
// Types for the communication error stop handler
package cesh_pkg;

    // Gray along normal -> wait -> decel -> trip
    typedef enum logic [2:0] {
        CESH_NORMAL = 3'h0,
        CESH_WAIT   = 3'h1,
        CESH_DECEL  = 3'h3,
        CESH_TRIP   = 3'h2,
        CESH_HALT   = 3'h6,
        CESH_CONT   = 3'h7
    } cesh_state_type;

endpackage

// [core/cesh_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module cesh_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Asynchronous inputs and their settled copies
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ----------------------------------------
    // Per-bit chain
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            // Stage one feeds only stage two; a value counts once two and three agree
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    s1_ff  <= 1'b0;
                    s2_ff  <= 1'b0;
                    s3_ff  <= 1'b0;
                    out_ff <= 1'b0;
                end else begin
                    s1_ff <= asyncIn[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign syncOut[i] = out_ff;
        end
    endgenerate

endmodule

// [core/comm_error_stop_handler.sv]
// Communication error stop handler: fault qualification and stop response
//
// What this block does
// (RL1) Error settings act only in network mode
// (RL2) Wait time 0 to 999.8 s, 0.1 s steps
// (RL3) Error declared only after full wait elapses
// (RL4) Line recovering within wait is ignored
// (RL5) Occurrence counter increments on each line error, holding at FFFF
// (RL6) Writing zero clears counter; resets to zero
// (RL7) Counter saved hourly; may reload after reset
// (RL8) Stop mode field 0 to 3, reset zero
// (RL9) During wait: run, normal indication, no alarm
// (RL10) Option error: 0,3 coast; 1,2 decel first
// (RL11) Line recognition response depends on stop mode
// (RL12) Line clears: 0,1 held; 2 restarts; 3 continues
// (RL13) Option error clearing keeps stop and alarm
// (RL14) Line errors report codes HA1 and HA3
// (RL15) Option circuit errors report HF1 and HF3
// (RL16) Alarm drives relay and alarm status bit
// (RL17) Alarm output writes entry to alarm history
// (RL18) No alarm: temporary display, history untouched
// (RL19) Stops use decel time, restart accel time
// (RL20) Mode two restart reuses prior commands
// (RL21) Mode two: line clears mid-decel, reaccelerate
// (RL22) Data exchange stops on line/option errors
// (RL23) Wait timed in 0.1 s ticks; zero immediate
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cesh_params.svh"

module comm_error_stop_handler #(
    parameter int TICK_CYCLES = `CESH_TICK_CYC,
    parameter int HOUR_TICKS  = `CESH_HOUR_TICKS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Fault and drive status pins
    input  wire logic        lineErrIn,
    input  wire logic        lineErrKindIn,
    input  wire logic        optErrIn,
    input  wire logic        optErrKindIn,
    input  wire logic        netModeIn,
    input  wire logic        motorStoppedIn,
    // Drive commands
    output logic             coastStop,
    output logic             decelStop,
    output logic             restartPulse,
    output logic             reuseCommands,
    output logic             dataExchStop,
    // Indication, relay and alarm history
    output logic             fault_relay_output,
    output logic             faultIndicate,
    output logic      [7:0]  indCode,
    output logic             histWrite,
    output logic      [7:0]  histCode,
    output logic      [7:0]  dispCode,
    // Nonvolatile copy of the occurrence count
    input  wire logic [15:0] nvStoredCount,
    input  wire logic        nvStoredValid,
    output logic             nvSave,
    output logic      [15:0] nvSaveCount
);

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [5:0] pinSync;
    cesh_sync #(.WIDTH(6)) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  ({lineErrIn, lineErrKindIn, optErrIn, optErrKindIn,
                    netModeIn, motorStoppedIn}),
        .syncOut  (pinSync)
    );
    wire lineS  = pinSync[5];
    wire lineKS = pinSync[4];
    wire optS   = pinSync[3];
    wire optKS  = pinSync[2];
    wire netS   = pinSync[1];
    wire stopS  = pinSync[0];

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic [`CESH_WAIT_W-1:0] error_wait_time_ff;
    logic [`CESH_CNT_W-1:0]  error_occurrence_count_ff;
    logic [1:0]              error_stop_mode_ff;
    cesh_pkg::cesh_state_type state_ff, nxt_state;
    logic                    kindOpt_ff, nxt_kindOpt;
    logic                    coastFlag_ff, nxt_coastFlag;
    logic [7:0]              code_ff, nxt_code;
    logic [7:0]              histLast_ff;
    logic                    lineS_ff;
    logic                    restorePend_ff;
    logic [24:0]             div_ff;
    logic [`CESH_WAIT_W-1:0] waitCnt_ff;
    logic [15:0]             hourCnt_ff;
    logic [31:0]             prdata_ff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire setup    = psel & ~penable;
    wire wrAcc    = psel & penable & pwrite;
    wire hitWait  = (paddr == `CESH_ADDR_WAIT);
    wire hitCount = (paddr == `CESH_ADDR_COUNT);
    wire hitMode  = (paddr == `CESH_ADDR_MODE);
    wire hitStat  = (paddr == `CESH_ADDR_STATUS);
    wire hitHist  = (paddr == `CESH_ADDR_HIST);
    wire hitAny   = hitWait | hitCount | hitMode | hitStat | hitHist;
    wire wrWait   = wrAcc & hitWait & (pwdata[`CESH_WAIT_W-1:0] <= `CESH_WAIT_MAX);
    wire wrClear  = wrAcc & hitCount & (pwdata == 32'h0000_0000);
    wire wrMode   = wrAcc & hitMode;
    wire [31:0] statusWord;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hitAny;
    assign prdata  = prdata_ff;

    // Read data captured in the setup cycle
    wire [31:0] rdMux =
        hitWait  ? {18'h00000, error_wait_time_ff} :
        hitCount ? {16'h0000, error_occurrence_count_ff} :
        hitMode  ? {30'h00000000, error_stop_mode_ff} :
        hitStat  ? statusWord :
        hitHist  ? {24'h000000, histLast_ff} : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_ff <= rdMux;
        end
    end

    // ----------------------------------------
    // Settings registers
    // ----------------------------------------
    // Out-of-range wait values are ignored rather than clipped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            error_wait_time_ff <= `CESH_WAIT_RST; // RL2
            error_stop_mode_ff <= `CESH_MODE_RST; // RL8
        end else begin
            if (wrWait) begin
                error_wait_time_ff <= pwdata[`CESH_WAIT_W-1:0]; // RL2
            end
            if (wrMode) begin
                error_stop_mode_ff <= pwdata[1:0]; // RL8
            end
        end
    end

    // ----------------------------------------
    // Occurrence counter
    // ----------------------------------------
    wire lineRise = lineS & ~lineS_ff;
    wire cntSat   = (error_occurrence_count_ff == `CESH_CNT_MAX);
    // Clear then add, so an error in the clearing cycle still counts
    wire [`CESH_CNT_W-1:0] cntBase = wrClear ? `CESH_CNT_RST : error_occurrence_count_ff;
    wire [`CESH_CNT_W-1:0] nxt_count =
        (lineRise && !(cntSat && !wrClear)) ? cntBase + 16'h0001 : cntBase;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            error_occurrence_count_ff <= `CESH_CNT_RST; // RL6
            lineS_ff                  <= 1'b0;
            restorePend_ff            <= 1'b1;
        end else begin
            lineS_ff       <= lineS;
            restorePend_ff <= 1'b0;
            if (restorePend_ff && nvStoredValid) begin
                error_occurrence_count_ff <= nvStoredCount; // RL7
            end else begin
                error_occurrence_count_ff <= nxt_count; // RL5 RL6
            end
        end
    end

    // ----------------------------------------
    // Tick divider, wait timer, hourly save
    // ----------------------------------------
    wire waitStart = (state_ff != cesh_pkg::CESH_WAIT) && (nxt_state == cesh_pkg::CESH_WAIT);
    wire tick      = (div_ff == 25'(TICK_CYCLES - 1));
    wire hourEnd   = tick && (hourCnt_ff == 16'(HOUR_TICKS - 1));

    // Divider restarts at wait entry so the full time always elapses; the
    // hourly save drifts slightly as a result, which is harmless
    always_ff @(posedge core_clk) begin
        if (sys_rst || waitStart || tick) begin
            div_ff <= 25'h0000000; // RL23
        end else begin
            div_ff <= div_ff + 25'h0000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || waitStart) begin
            waitCnt_ff <= `CESH_WAIT_RST;
        end else if (tick && waitCnt_ff != `CESH_WAIT_MAX) begin
            waitCnt_ff <= waitCnt_ff + 14'h0001; // RL23
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hourCnt_ff  <= 16'h0000;
            nvSave      <= 1'b0;
            nvSaveCount <= `CESH_CNT_RST;
        end else begin
            nvSave <= hourEnd; // RL7
            if (tick) begin
                hourCnt_ff <= hourEnd ? 16'h0000 : hourCnt_ff + 16'h0001;
            end
            if (hourEnd) begin
                nvSaveCount <= error_occurrence_count_ff; // RL7
            end
        end
    end

    // ----------------------------------------
    // Response selection
    // ----------------------------------------
    // Errors stop the drive only in network operation; dataExchStop follows the raw inputs in any mode
    wire lineOn   = lineS & netS; // RL1 RL22
    wire optOn    = optS & netS; // RL22
    wire waitDone = (waitCnt_ff >= error_wait_time_ff); // RL3
    wire zeroWait = (error_wait_time_ff == `CESH_WAIT_RST); // RL23
    wire modeTwo  = (error_stop_mode_ff == 2'h2);
    wire optCoast = (error_stop_mode_ff == 2'h0) || (error_stop_mode_ff == 2'h3); // RL10
    wire [7:0] optCode  = optKS ? `CESH_CODE_HF3 : `CESH_CODE_HF1; // RL15
    wire [7:0] lineCode = lineKS ? `CESH_CODE_HA3 : `CESH_CODE_HA1; // RL14
    wire cesh_pkg::cesh_state_type optTgt =
        optCoast ? cesh_pkg::CESH_TRIP : cesh_pkg::CESH_DECEL; // RL10
    wire cesh_pkg::cesh_state_type lineTgt =
        (error_stop_mode_ff == 2'h0) ? cesh_pkg::CESH_TRIP :
        (error_stop_mode_ff == 2'h3) ? cesh_pkg::CESH_CONT :
        cesh_pkg::CESH_DECEL; // RL11

    // Next-state logic; the option error always takes precedence
    always_comb begin
        nxt_state     = state_ff;
        nxt_kindOpt   = kindOpt_ff;
        nxt_coastFlag = coastFlag_ff;
        nxt_code      = code_ff;
        case (state_ff)
            cesh_pkg::CESH_NORMAL, cesh_pkg::CESH_WAIT,
            cesh_pkg::CESH_HALT, cesh_pkg::CESH_CONT: begin
                if (optOn) begin
                    nxt_state     = optTgt; // RL10
                    nxt_kindOpt   = 1'b1;
                    nxt_coastFlag = optCoast;
                    nxt_code      = optCode;
                end else if (!lineOn) begin
                    nxt_state = cesh_pkg::CESH_NORMAL; // RL4 RL12
                end else if (state_ff == cesh_pkg::CESH_NORMAL && !zeroWait) begin
                    nxt_state = cesh_pkg::CESH_WAIT; // RL9
                end else if ((state_ff == cesh_pkg::CESH_NORMAL) ||
                             (state_ff == cesh_pkg::CESH_WAIT && waitDone)) begin
                    nxt_state     = lineTgt; // RL3 RL11 RL23
                    nxt_kindOpt   = 1'b0;
                    nxt_coastFlag = (error_stop_mode_ff == 2'h0);
                    nxt_code      = lineCode;
                end
            end
            cesh_pkg::CESH_DECEL: begin
                if (optOn && !kindOpt_ff) begin
                    nxt_kindOpt = 1'b1;
                    nxt_code    = optCode;
                end else if (!kindOpt_ff && modeTwo && !lineOn) begin
                    nxt_state = cesh_pkg::CESH_NORMAL; // RL21
                end else if (stopS) begin
                    nxt_state = (!kindOpt_ff && modeTwo) ?
                                cesh_pkg::CESH_HALT : cesh_pkg::CESH_TRIP; // RL11 RL10
                end
            end
            // Trip is left only by reset
            cesh_pkg::CESH_TRIP: begin
                nxt_state = cesh_pkg::CESH_TRIP; // RL12 RL13
            end
            default: begin
                nxt_state = cesh_pkg::CESH_NORMAL;
            end
        endcase
    end

    // ----------------------------------------
    // Drive command and indication outputs
    // ----------------------------------------
    wire nxtTrip    = (nxt_state == cesh_pkg::CESH_TRIP);
    wire nxtHalt    = (nxt_state == cesh_pkg::CESH_HALT);
    wire errActive  = (state_ff != cesh_pkg::CESH_NORMAL) &&
                      (state_ff != cesh_pkg::CESH_WAIT) && (state_ff != cesh_pkg::CESH_CONT);
    wire restartNow = errActive && (nxt_state == cesh_pkg::CESH_NORMAL);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff           <= cesh_pkg::CESH_NORMAL;
            kindOpt_ff         <= 1'b0;
            coastFlag_ff       <= 1'b0;
            code_ff            <= `CESH_CODE_NONE;
            coastStop          <= 1'b0;
            decelStop          <= 1'b0;
            restartPulse       <= 1'b0;
            reuseCommands      <= 1'b0;
            fault_relay_output <= 1'b0;
            faultIndicate      <= 1'b0;
            indCode            <= `CESH_CODE_NONE;
            histWrite          <= 1'b0;
            histCode           <= `CESH_CODE_NONE;
        end else begin
            state_ff      <= nxt_state;
            kindOpt_ff    <= nxt_kindOpt;
            coastFlag_ff  <= nxt_coastFlag;
            code_ff       <= nxt_code;
            coastStop     <= nxtTrip && nxt_coastFlag; // RL10 RL11
            // Ramp uses the drive's ordinary decel and accel time settings
            decelStop     <= (nxt_state == cesh_pkg::CESH_DECEL) || nxtHalt ||
                             (nxtTrip && !nxt_coastFlag); // RL19
            restartPulse  <= restartNow; // RL12 RL19 RL21
            reuseCommands <= !nxt_kindOpt && modeTwo &&
                             ((nxt_state == cesh_pkg::CESH_DECEL) || nxtHalt); // RL20
            fault_relay_output <= nxtTrip; // RL16
            faultIndicate <= nxtTrip || nxtHalt; // RL9
            indCode       <= (nxtTrip || nxtHalt) ? nxt_code : `CESH_CODE_NONE;
            histWrite     <= nxtTrip && (state_ff != cesh_pkg::CESH_TRIP); // RL17
            histCode      <= nxt_code; // RL17
        end
    end

    // ----------------------------------------
    // Alarm history and display
    // ----------------------------------------
    // Halt overlays the display without touching the stored entry
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            histLast_ff <= `CESH_CODE_NONE;
            dispCode    <= `CESH_CODE_NONE;
        end else begin
            if (histWrite) begin
                histLast_ff <= histCode; // RL17
            end
            dispCode <= nxtHalt ? nxt_code :
                        (histWrite ? histCode : histLast_ff); // RL18
        end
    end

    // Data exchange halts on any line or option error
    assign dataExchStop = lineS | optS; // RL22

    assign statusWord = {13'h0000, state_ff, code_ff, 3'h0, dataExchStop,
                         decelStop, coastStop, faultIndicate,
                         fault_relay_output}; // RL16

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_wait_no_alarm: assert property ( // RL9
        state_ff == cesh_pkg::CESH_WAIT |-> !fault_relay_output && !faultIndicate
    ) else $error("alarm or indication during wait");
    a_count_incr: assert property ( // RL5
        lineRise && !wrClear && !cntSat && !restorePend_ff |=>
        error_occurrence_count_ff == $past(error_occurrence_count_ff) + 16'h0001
    ) else $error("count did not increment");
    a_count_clear: assert property ( // RL6
        wrClear && !lineRise && !restorePend_ff |=> error_occurrence_count_ff == 16'h0000
    ) else $error("count not cleared");
    a_zero_wait: assert property ( // RL23
        state_ff == cesh_pkg::CESH_NORMAL && lineOn && !optOn && zeroWait |=>
        state_ff != cesh_pkg::CESH_WAIT && state_ff != cesh_pkg::CESH_NORMAL
    ) else $error("zero wait did not recognize at once");
    a_early_clear: assert property ( // RL4
        state_ff == cesh_pkg::CESH_WAIT && !lineOn && !optOn |=>
        state_ff == cesh_pkg::CESH_NORMAL ##1 !fault_relay_output
    ) else $error("early recovery not ignored");
    a_trip_held: assert property ( // RL13
        state_ff == cesh_pkg::CESH_TRIP |=> fault_relay_output [*3]
    ) else $error("trip alarm not held");
    a_hist_alarm: assert property ( // RL17
        $rose(fault_relay_output) |-> histWrite && histCode == indCode
    ) else $error("alarm without history write");
    a_halt_display: assert property ( // RL18
        state_ff == cesh_pkg::CESH_HALT |-> dispCode == code_ff && !fault_relay_output
    ) else $error("halt display wrong");
    a_halt_restart: assert property ( // RL12
        state_ff == cesh_pkg::CESH_HALT && !lineOn && !optOn |=> restartPulse
    ) else $error("mode two did not restart");
    a_offline_quiet: assert property ( // RL1
        state_ff == cesh_pkg::CESH_NORMAL && !netS |=> state_ff == cesh_pkg::CESH_NORMAL
    ) else $error("error acted outside network mode");

    c_mode0_trip: cover property (lineRise ##[1:50] coastStop);
    c_mode2_restart: cover property (state_ff == cesh_pkg::CESH_HALT ##1 restartPulse);
    c_opt_decel: cover property (kindOpt_ff && state_ff == cesh_pkg::CESH_DECEL);
    c_hour_save: cover property (nvSave);

endmodule

// [dv/cesh_master_model.sv]
// Network master station model: frames stop while the link is down
`timescale 1ns/1ps

module cesh_master_model (
    // Clock
    input  wire logic core_clk,
    // Bench control
    input  wire logic linkDown,
    input  wire logic kindSel,
    // Line error view seen by the option
    output logic      lineErrIn,
    output logic      lineErrKindIn
);
    // Lost frames show up one cycle after the bench drops the link
    always_ff @(posedge core_clk) begin
        lineErrIn     <= linkDown;
        lineErrKindIn <= kindSel;
    end
endmodule

// [dv/comm_error_stop_handler_test.sv]
// Self-checking bench for the communication error stop handler
`timescale 1ns/1ps
`include "cesh_params.svh"

module comm_error_stop_handler_test;
    // ----
    // Signals and scoreboard
    // ----
    localparam logic [31:0] SM = 32'h0007_FF07;
    logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, histCode;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000_0047;
    logic pready, histWrite, restartPulse, lineErrIn, lineErrKindIn, linkDown = 1'b0;
    logic kindSel = 1'b0, optErrIn = 1'b0, optErrKindIn = 1'b0, netModeIn = 1'b1;
    logic motorStoppedIn = 1'b1, nvStoredValid = 1'b0;
    logic [15:0] nvStoredCount = 16'h0005;
    logic [63:0] noteQ[$];
    logic [7:0] histQ[$];
    int errors = 0, tests_run = 0, restarts = 0, cycles = 0;

    cesh_master_model i_cesh_master_model (.core_clk, .linkDown, .kindSel, .lineErrIn,
        .lineErrKindIn);
    comm_error_stop_handler #(.TICK_CYCLES(10), .HOUR_TICKS(4)) i_comm_error_stop_handler (
        .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr(), .lineErrIn, .lineErrKindIn, .optErrIn, .optErrKindIn, .netModeIn,
        .motorStoppedIn, .coastStop(), .decelStop(), .restartPulse, .reuseCommands(),
        .dataExchStop(), .fault_relay_output(), .faultIndicate(), .indCode(), .histWrite,
        .histCode, .dispCode(), .nvStoredCount, .nvStoredValid, .nvSave(), .nvSaveCount());

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] st(input logic [2:0] s, input logic [7:0] c,
                                       input logic [2:0] cir);
        return {13'h0000, s, c, 5'h00, cir};
    endfunction
    function automatic logic [7:0] lcode();
        return kindSel ? `CESH_CODE_HA3 : `CESH_CODE_HA1;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // APB master: holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) noteQ.push_back({m, d});
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && cycles < 5000);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Link drop with a random error kind
    task automatic line_err(input int hold);
        seed = xorshift(seed);
        @(posedge core_clk);
        kindSel <= seed[0];
        linkDown <= 1'b1;
        wait_cyc(hold);
    endtask
    task automatic clr();
        linkDown <= 1'b0;
        wait_cyc(10);
    endtask
    task automatic do_reset(input logic nv);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        nvStoredValid <= nv;
        wait_cyc(16);
        sys_rst <= 1'b0;
        wait_cyc(2);
    endtask

    // ----
    // Clock, timeout and output watcher
    // ----
    initial forever #2.5 core_clk = ~core_clk;
    // Oldest note is matched against each completed read; each history write is matched against the oldest histQ entry
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check(prdata & noteQ[0][63:32], noteQ[0][31:0] & noteQ[0][63:32]);
            void'(noteQ.pop_front());
        end
        if (histWrite === 1'b1) check({24'h0, histCode}, {24'h0, histQ.pop_front()});
        if (restartPulse === 1'b1) restarts++;
    end

    // ----
    // Scenarios
    // ----
    initial begin
        do_reset(1'b0);
        apb(0, `CESH_ADDR_WAIT, 0, '1);
        apb(0, `CESH_ADDR_COUNT, 0, '1);
        apb(0, `CESH_ADDR_MODE, 0, '1);
        apb(0, 8'h40, 0, '1);
        apb(1, `CESH_ADDR_WAIT, 32'h270E, 0);
        apb(1, `CESH_ADDR_WAIT, 32'h270F, 0);
        apb(0, `CESH_ADDR_WAIT, 32'h270E, '1);
        apb(1, `CESH_ADDR_WAIT, 3, 0);
        apb(1, `CESH_ADDR_MODE, 3, 0);
        line_err(12);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_WAIT, 0, 0), SM);
        clr();
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_NORMAL, 0, 0), SM);
        line_err(50);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_CONT, lcode(), 0), SM);
        clr();
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_NORMAL, lcode(), 0), SM);
        apb(0, `CESH_ADDR_COUNT, 2, '1);
        apb(1, `CESH_ADDR_COUNT, 5, 0);
        apb(1, `CESH_ADDR_COUNT, 0, 0);
        apb(0, `CESH_ADDR_COUNT, 0, '1);
        apb(1, `CESH_ADDR_WAIT, 0, 0);
        apb(1, `CESH_ADDR_MODE, 2, 0);
        line_err(16);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_HALT, lcode(), 3'h2), SM);
        clr();
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_NORMAL, lcode(), 0), SM);
        check(restarts, 1);
        // Line clears while still ramping down: restart from that point
        motorStoppedIn <= 1'b0;
        line_err(16);
        clr();
        check(restarts, 2);
        apb(1, `CESH_ADDR_MODE, 0, 0);
        histQ.push_back(xorshift(seed) % 2 ? `CESH_CODE_HA3 : `CESH_CODE_HA1);
        line_err(16);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_TRIP, lcode(), 3'h7), SM);
        clr();
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_TRIP, lcode(), 3'h7), SM);
        apb(0, `CESH_ADDR_HIST, lcode(), '1);
        do_reset(1'b1);
        apb(0, `CESH_ADDR_COUNT, 5, '1);
        netModeIn <= 1'b0;
        line_err(16);
        apb(0, `CESH_ADDR_STATUS, st(0, 0, 0) | 32'h10, SM | 32'h10);
        clr();
        netModeIn <= 1'b1;
        apb(1, `CESH_ADDR_MODE, 1, 0);
        histQ.push_back(`CESH_CODE_HF3);
        motorStoppedIn <= 1'b0;
        optErrKindIn <= 1'b1;
        optErrIn <= 1'b1;
        wait_cyc(12);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_DECEL, 0, 0), 32'h0007_0003);
        motorStoppedIn <= 1'b1;
        wait_cyc(10);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_TRIP, `CESH_CODE_HF3, 3'h3), SM);
        optErrIn <= 1'b0;
        wait_cyc(10);
        apb(0, `CESH_ADDR_STATUS, st(cesh_pkg::CESH_TRIP, `CESH_CODE_HF3, 3'h3), SM);
        check(restarts, 2);
        finish_test();
    end
endmodule
